// ==== lpmr_mode_registers.v ====
// Mode register bank for addresses 02h..07h of a low-power DDR2 memory
// Operation
// [R1] Address 02h low nibble is write-only latency select, codes 1..6 valid, default 1.
// [R2] Address 03h low nibble is write-only drive strength, codes 1,2,3,4,6,7 valid.
// [R3] Refresh field at 04h bits 2:0 shows 001b for 4x and 010b for 2x refresh rate.
// [R4] Code 101b asks quarter-interval refresh without de-rating, 110b with de-rating.
// [R5] Code 111b reports that the high-temperature operating limit is exceeded.
// [R6] Bit 7 of 04h is set when the refresh field changed since the last read of 04h.
// [R7] A mode read of 04h clears bit 7 as a side effect.
// [R8] The update flag is cleared at power-up.
// [R9] Refresh field bit 2 set means the device is above 85 degrees Celsius.
// [R10] The controller lengthens core row timings by 1.875ns when de-rating is asked; the model only inserts one idle cycle before each command.
// [R11] The controller treats codes 000b and 111b as unsafe operation.
// [R12] Address 05h returns a fixed manufacturer code, read-only.
// [R13] Address 06h returns the first fixed revision code, read-only.
// [R14] Address 07h returns the second fixed revision code, read-only.
// [R15] A change coinciding with a read of 04h leaves the update flag set.
`timescale 1ns/1ps
`include "lpmr_defines.vh"

module lpmr_mode_registers (
  input wire ref_clk,
  input wire rst,
  input wire modeWrite,
  input wire modeRead,
  input wire [7:0] modeAddress,
  input wire [7:0] operandBits,
  input wire [2:0] sensorRate,
  output reg [7:0] readData,
  output reg readValid,
  output reg [3:0] readLatencyCycles,
  output reg [3:0] writeLatencyCycles,
  output reg [3:0] driveStrengthSelect,
  output wire deRateTiming,
  output wire overTemperature,
  output wire unsafeOperation
);

  reg [3:0] latencySelect;
  reg [3:0] ioDriveConfig;
  reg [3:0] next_latencySelect;
  reg [3:0] next_ioDriveConfig;
  wire [3:0] lowOperand;
  reg [7:0] next_readData;
  wire [2:0] rateCode;
  wire temperatureUpdateFlag;
  wire tempRead;
  wire latencyWrite;
  wire driveWrite;

  // Latency code check; reserved codes are refused
  function latency_ok;
    input [3:0] code;
    begin
      latency_ok = (code >= `LPMR_LAT_3_1) && (code <= `LPMR_LAT_8_4);
    end
  endfunction

  // Drive code check; 0000b, 0101b and 1000b to 1111b are reserved
  function drive_ok;
    input [3:0] code;
    begin
      case (code)
        `LPMR_DRV_34, `LPMR_DRV_40, `LPMR_DRV_48, `LPMR_DRV_60, `LPMR_DRV_80, `LPMR_DRV_120:
          drive_ok = 1'b1;
        default:
          drive_ok = 1'b0;
      endcase
    end
  endfunction

  // Read latency in cycles; any code not stored falls back to the default
  function [3:0] read_cycles_of;
    input [3:0] code;
    begin
      case (code)
        `LPMR_LAT_4_2:
          read_cycles_of = `LPMR_READ_CYC_4;
        `LPMR_LAT_5_2:
          read_cycles_of = `LPMR_READ_CYC_5;
        `LPMR_LAT_6_3:
          read_cycles_of = `LPMR_READ_CYC_6;
        `LPMR_LAT_7_4:
          read_cycles_of = `LPMR_READ_CYC_7;
        `LPMR_LAT_8_4:
          read_cycles_of = `LPMR_READ_CYC_8;
        default:
          read_cycles_of = `LPMR_READ_CYC_3;
      endcase
    end
  endfunction

  // Write latency in cycles; two pairs of codes share a value, so no simple offset
  function [3:0] write_cycles_of;
    input [3:0] code;
    begin
      case (code)
        `LPMR_LAT_4_2:
          write_cycles_of = `LPMR_WRITE_CYC_2;
        `LPMR_LAT_5_2:
          write_cycles_of = `LPMR_WRITE_CYC_2;
        `LPMR_LAT_6_3:
          write_cycles_of = `LPMR_WRITE_CYC_3;
        `LPMR_LAT_7_4:
          write_cycles_of = `LPMR_WRITE_CYC_4;
        `LPMR_LAT_8_4:
          write_cycles_of = `LPMR_WRITE_CYC_4;
        default:
          write_cycles_of = `LPMR_WRITE_CYC_1;
      endcase
    end
  endfunction

  // Codes under which correct operation is not assured
  function rate_unsafe;
    input [2:0] code;
    begin
      rate_unsafe = (code == `LPMR_RATE_UNSAFE) || (code == `LPMR_RATE_LIMIT);
    end
  endfunction

  // Address decodes; a read of the status address clears the update flag
  assign tempRead = modeRead && (modeAddress == `LPMR_ADDR_TEMP);
  assign latencyWrite = modeWrite && (modeAddress == `LPMR_ADDR_LATENCY);
  assign driveWrite = modeWrite && (modeAddress == `LPMR_ADDR_DRIVE);
  assign lowOperand = operandBits[`LPMR_LOW_MSB:0];

  // Refresh status holder, fed straight from the sensor on every edge
  lpmr_rate_tracker tracker (
    .ref_clk(ref_clk),
    .rst(rst),
    .rateIn(sensorRate),
    .clearFlag(tempRead), // [R7]
    .rateCode(rateCode), // [R3] [R4] [R5]
    .updateFlag(temperatureUpdateFlag) // [R6]
  );

  // Next settings; a reserved code leaves the old setting in place
  always @*
  begin
    next_latencySelect = latencySelect;
    next_ioDriveConfig = ioDriveConfig;
    if (latencyWrite && latency_ok(lowOperand))
      next_latencySelect = lowOperand; // [R1]
    if (driveWrite && drive_ok(lowOperand))
      next_ioDriveConfig = lowOperand; // [R2]
  end

  // Write-only fields; nothing reads them back, the decodes below show them
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      latencySelect <= `LPMR_LATENCY_RESET;
      ioDriveConfig <= `LPMR_DRIVE_RESET;
    end
    else
    begin
      latencySelect <= next_latencySelect;
      ioDriveConfig <= next_ioDriveConfig;
    end
  end

  // Decode latency into cycle counts, registered so the datapath never sees a glitch
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      readLatencyCycles <= `LPMR_READ_CYC_3;
      writeLatencyCycles <= `LPMR_WRITE_CYC_1;
      driveStrengthSelect <= `LPMR_DRIVE_RESET;
    end
    else
    begin
      driveStrengthSelect <= ioDriveConfig; // [R2]
      readLatencyCycles <= read_cycles_of(latencySelect); // [R1]
      writeLatencyCycles <= write_cycles_of(latencySelect); // [R1]
    end
  end

  // Status decodes from the refresh code
  assign deRateTiming = (rateCode == `LPMR_RATE_QTR_DERATE); // [R4]
  assign overTemperature = rateCode[`LPMR_HOT_BIT]; // [R9]
  assign unsafeOperation = rate_unsafe(rateCode); // [R5]

  // Read mux; write-only and unmapped addresses return zero
  always @*
  begin
    next_readData = readData;
    if (modeRead)
    begin
      case (modeAddress)
        `LPMR_ADDR_TEMP:
          next_readData = {temperatureUpdateFlag, `LPMR_ZERO4, rateCode}; // [R3] [R6]
        `LPMR_ADDR_MAKER:
          next_readData = `LPMR_MAKER_ID; // [R12]
        `LPMR_ADDR_REV_ONE:
          next_readData = `LPMR_REV_ONE_ID; // [R13]
        `LPMR_ADDR_REV_TWO:
          next_readData = `LPMR_REV_TWO_ID; // [R14]
        default:
          next_readData = `LPMR_ZERO8;
      endcase
    end
  end

  // Read port; the answer holds until the next read replaces it
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      readData <= `LPMR_ZERO8;
      readValid <= 1'b0;
    end
    else
    begin
      readValid <= modeRead;
      readData <= next_readData;
    end
  end

endmodule

// ==== lpmr_defines.vh ====
// Constants for the mode register bank, addresses 02h to 07h
`ifndef LPMR_DEFINES_VH
`define LPMR_DEFINES_VH

// Mode addresses
`define LPMR_ADDR_LATENCY 8'h02
`define LPMR_ADDR_DRIVE 8'h03
`define LPMR_ADDR_TEMP 8'h04
`define LPMR_ADDR_MAKER 8'h05
`define LPMR_ADDR_REV_ONE 8'h06
`define LPMR_ADDR_REV_TWO 8'h07

// Reset values
`define LPMR_LATENCY_RESET 4'h1
`define LPMR_DRIVE_RESET 4'h2
`define LPMR_RATE_RESET 3'h3

// Field positions
`define LPMR_LOW_MSB 3
`define LPMR_RATE_MSB 2
`define LPMR_FLAG_BIT 7
`define LPMR_HOT_BIT 2

// Latency codes
`define LPMR_LAT_3_1 4'h1
`define LPMR_LAT_4_2 4'h2
`define LPMR_LAT_5_2 4'h3
`define LPMR_LAT_6_3 4'h4
`define LPMR_LAT_7_4 4'h5
`define LPMR_LAT_8_4 4'h6

// Latency in clock cycles per latency code
`define LPMR_READ_CYC_3 4'h3
`define LPMR_READ_CYC_4 4'h4
`define LPMR_READ_CYC_5 4'h5
`define LPMR_READ_CYC_6 4'h6
`define LPMR_READ_CYC_7 4'h7
`define LPMR_READ_CYC_8 4'h8
`define LPMR_WRITE_CYC_1 4'h1
`define LPMR_WRITE_CYC_2 4'h2
`define LPMR_WRITE_CYC_3 4'h3
`define LPMR_WRITE_CYC_4 4'h4

// Drive strength codes
`define LPMR_DRV_34 4'h1
`define LPMR_DRV_40 4'h2
`define LPMR_DRV_48 4'h3
`define LPMR_DRV_60 4'h4
`define LPMR_DRV_80 4'h6
`define LPMR_DRV_120 4'h7

// Refresh-rate codes
`define LPMR_RATE_UNSAFE 3'h0
`define LPMR_RATE_4X 3'h1
`define LPMR_RATE_2X 3'h2
`define LPMR_RATE_1X 3'h3
`define LPMR_RATE_QTR 3'h5
`define LPMR_RATE_QTR_DERATE 3'h6
`define LPMR_RATE_LIMIT 3'h7

// Identity codes, values arbitrary
`define LPMR_MAKER_ID 8'h5a
`define LPMR_REV_ONE_ID 8'h11
`define LPMR_REV_TWO_ID 8'h22

`define LPMR_ZERO8 8'h00
`define LPMR_ZERO5 5'h00
`define LPMR_ZERO4 4'h0
`endif

// ==== lpmr_rate_tracker.v ====
// Refresh-rate status holder with its sticky change flag
`timescale 1ns/1ps
`include "lpmr_defines.vh"

module lpmr_rate_tracker (
  input wire ref_clk,
  input wire rst,
  input wire [2:0] rateIn,
  input wire clearFlag,
  output reg [2:0] rateCode,
  output reg updateFlag
);

  wire changed;

  assign changed = (rateIn != rateCode);

  // Capture the sensor code; set beats the read clear so no change is lost
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rateCode <= `LPMR_RATE_RESET;
      updateFlag <= 1'b0; // [R8]
    end
    else
    begin
      rateCode <= rateIn;
      if (changed)
        updateFlag <= 1'b1; // [R6] [R15]
      else if (clearFlag)
        updateFlag <= 1'b0; // [R7]
    end
  end

endmodule

// ==== lpmr_monitor.sv ====
// Assertion checker for the mode register bank
`timescale 1ns/1ps
`include "lpmr_defines.vh"
module lpmr_monitor (
  input wire ref_clk,
  input wire rst,
  input wire modeWrite,
  input wire modeRead,
  input wire [7:0] modeAddress,
  input wire [7:0] operandBits,
  input wire [2:0] sensorRate,
  input wire [7:0] readData,
  input wire [3:0] readLatencyCycles,
  input wire [3:0] driveStrengthSelect,
  input wire overTemperature
);
  reg [2:0] rate;
  wire rd4 = modeRead && modeAddress == 8'h04;
  wire [3:0] low = operandBits[3:0];
  // Stored refresh code, one edge behind the sensor
  always @(posedge ref_clk or posedge rst)
    if (rst)
      rate <= 3'h3;
    else
      rate <= sensorRate;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_maker_code:
    assert property (modeRead && modeAddress == 8'h05 |=> readData == `LPMR_MAKER_ID)
    else $error("maker code wrong");
  a_wo_silent:
    assert property (modeRead && modeAddress[7:1] == 7'h01 |=> readData == 8'h00)
    else $error("write-only read not zero");
  a_lat_decode:
    assert property (modeWrite && modeAddress == 8'h02 && low - 4'h1 < 4'h6
      |-> ##2 readLatencyCycles == $past(low, 2) + 4'h2)
    else $error("latency decode wrong");
  a_drive_keep:
    assert property (modeWrite && modeAddress == 8'h03 && !(low inside {1, 2, 3, 4, 6, 7})
      |-> ##2 $stable(driveStrengthSelect))
    else $error("reserved drive code taken");
  a_rate_report:
    assert property (rd4 |=> readData[6:0] == {4'h0, $past(rate)})
    else $error("refresh field wrong");
  a_flag_set:
    assert property (rd4 && rate != $past(rate) |=> readData[7])
    else $error("update flag lost");
  a_flag_clear:
    assert property (rd4 ##1 (rd4 && rate == $past(rate)) |=> !readData[7])
    else $error("update flag not cleared");
  a_hot_bit:
    assert property (overTemperature == rate[2])
    else $error("hot indication wrong");
  a_rev_one:
    assert property (modeRead && modeAddress == 8'h06 |=> readData == `LPMR_REV_ONE_ID)
    else $error("first revision code wrong");
  a_rev_two:
    assert property (modeRead && modeAddress == 8'h07 |=> readData == `LPMR_REV_TWO_ID)
    else $error("second revision code wrong");
endmodule
bind lpmr_mode_registers lpmr_monitor mon (.*);

// ==== lpmr_ctrl_model.sv ====
// Memory controller model issuing mode register commands
`timescale 1ns/1ps
module lpmr_ctrl_model (
  input wire ref_clk,
  input wire deRateTiming,
  input wire unsafeOperation,
  output reg modeWrite = 1'b0,
  output reg modeRead = 1'b0,
  output reg [7:0] modeAddress = 8'h00,
  output reg [7:0] operandBits = 8'h00
);
  // One command per call, held until the next call replaces it
  task cmd(input w, input r, input [7:0] a, input [7:0] d);
    begin
      // Slower pacing while core timing is de-rated or status unsafe
      if (deRateTiming | unsafeOperation)
      begin
        @(posedge ref_clk);
        #1;
        {modeWrite, modeRead} = 2'b00;
      end
      @(posedge ref_clk);
      #1;
      {modeWrite, modeRead, modeAddress, operandBits} = {w, r, a, d};
    end
  endtask
endmodule

// ==== lpmr_mode_registers_tb_top.sv ====
// Self-checking bench for the mode register bank
`timescale 1ns/1ps
`include "lpmr_defines.vh"
module lpmr_mode_registers_tb_top;
  reg ref_clk = 0;
  reg rst = 1;
  reg [2:0] sensorRate = 3'h3;
  reg [3:0] hi, expRead = 4'h3, expWrite = 4'h1, expDrive = 4'h2;
  wire modeWrite, modeRead, readValid, deRateTiming, overTemperature, unsafeOperation;
  wire [7:0] modeAddress, operandBits, readData;
  wire [3:0] readLatencyCycles, writeLatencyCycles, driveStrengthSelect;
  integer mismatches = 0, cmp_count = 0, seed = 32'hed32, c;
  reg [7:0] expQ[$];
  always #12.5 ref_clk = ~ref_clk;
  lpmr_mode_registers dut (
    .ref_clk(ref_clk),
    .rst(rst),
    .modeWrite(modeWrite),
    .modeRead(modeRead),
    .modeAddress(modeAddress),
    .operandBits(operandBits),
    .sensorRate(sensorRate),
    .readData(readData),
    .readValid(readValid),
    .readLatencyCycles(readLatencyCycles),
    .writeLatencyCycles(writeLatencyCycles),
    .driveStrengthSelect(driveStrengthSelect),
    .deRateTiming(deRateTiming),
    .overTemperature(overTemperature),
    .unsafeOperation(unsafeOperation)
  );
  lpmr_ctrl_model ctl (
    .ref_clk(ref_clk),
    .deRateTiming(deRateTiming),
    .unsafeOperation(unsafeOperation),
    .modeWrite(modeWrite),
    .modeRead(modeRead),
    .modeAddress(modeAddress),
    .operandBits(operandBits)
  );
  task chk(input [7:0] act, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (act !== exp)
      begin
        mismatches = mismatches + 1;
        $display("[ERR] %0t got %h want %h", $time, act, exp);
      end
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      ctl.cmd(0, 1, a, 8'h00);
      expQ.push_back(e);
    end
  endtask
  task conclude;
    begin
      $display("mismatches %0d cmp_count %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Each answer against the oldest note
  always @(posedge ref_clk)
    if (readValid === 1'b1)
      chk(readData, expQ.pop_front());
  initial
  begin
    #100000;
    mismatches = mismatches + 1;
    conclude;
  end
  initial
  begin
    repeat (5) @(posedge ref_clk);
    #1 rst = 0;
    rd(8'h04, 8'h03);
    rd(8'h05, `LPMR_MAKER_ID);
    rd(8'h06, `LPMR_REV_ONE_ID);
    rd(8'h07, `LPMR_REV_TWO_ID);
    rd(8'h03, 8'h00);
    rd(8'h08, 8'h00);
    // Every refresh code, each one a change
    for (c = 0; c < 8; c = c + 1)
    begin
      sensorRate = c[2:0];
      rd(8'h04, {5'h10, c[2:0]});
      rd(8'h04, {5'h00, c[2:0]});
      chk(deRateTiming, c == 6);
      chk(unsafeOperation, c == 0 || c == 7);
      chk(overTemperature, c[2]);
    end
    // Change lands on the edge of a read
    rd(8'h04, 8'h07);
    sensorRate = 3'h5;
    rd(8'h04, 8'h85);
    rd(8'h04, 8'h05);
    for (c = 0; c < 16; c = c + 1)
    begin
      hi = $random(seed);
      ctl.cmd(1, 0, 8'h02, {hi, c[3:0]});
      ctl.cmd(1, 0, 8'h03, {~hi, c[3:0]});
      ctl.cmd(0, 0, 8'h00, 8'h00);
      repeat (2) @(posedge ref_clk);
      #1;
      if (c > 0 && c < 7)
      begin
        expRead = c[3:0] + 4'h2;
        expWrite = c[3:0] - {3'h0, c > 2} - {3'h0, c > 5};
      end
      if (c inside {1, 2, 3, 4, 6, 7})
        expDrive = c[3:0];
      chk(readLatencyCycles, expRead);
      chk(writeLatencyCycles, expWrite);
      chk(driveStrengthSelect, expDrive);
    end
    repeat (3) @(posedge ref_clk);
    conclude;
  end
endmodule
